//--- include/shsp_pkg.sv
package shsp_pkg;
	// Register offsets on the bus
	localparam logic [7:0]  SHSP_CTRL_OFS     = 8'h00;
	localparam logic [7:0]  SHSP_STAT_OFS     = 8'h04;
	localparam logic [2:0]  SHSP_CTRL_RST     = 3'h0;
	// Control field positions
	localparam int          SHSP_S17_BIT      = 0;
	localparam int          SHSP_HCE_BIT      = 1;
	localparam int          SHSP_SLD_BIT      = 2;
	// Status field positions
	localparam int          SHSP_IER_BIT      = 0;
	localparam int          SHSP_CRC_BIT      = 1;
	localparam int          SHSP_MODE_BIT     = 2;
	localparam int          SHSP_BUSY_BIT     = 3;
	localparam int          SHSP_ID_LSB       = 4;
	// Serial frame lengths
	localparam logic [4:0]  SHSP_LEN_BASE     = 5'h10;
	localparam logic [4:0]  SHSP_LEN_EXT      = 5'h11;
	localparam logic [4:0]  SHSP_LEN_CRC      = 5'h14;
	localparam logic [3:0]  SHSP_CRC4_PRESET  = 4'hF;
	localparam logic [2:0]  SHSP_CRC3_PRESET  = 3'h7;
	// Supply-line frame lengths including sync bits
	localparam logic [5:0]  SHSP_MAN_RD_LEN   = 6'h10;
	localparam logic [5:0]  SHSP_MAN_WR_LEN   = 6'h20;
	localparam logic [5:0]  SHSP_ACCESS_ADDR  = 6'h3F;
	localparam logic [15:0] SHSP_ACCESS_DATA  = 16'h62D2;
	localparam logic [15:0] SHSP_EXIT_DATA    = 16'h5AA5;
	localparam logic [1:0]  SHSP_ID_SETTLE    = 2'h3;

	typedef enum logic [1:0] {
		SHSP_M_IDLE = 2'b00,
		SHSP_M_SYNC = 2'b01,
		SHSP_M_BITS = 2'b10
	} shsp_man_t;

	function automatic logic [3:0] shsp_crc4_step(input logic [3:0] c, input logic b);
		logic inv;
		inv = b ^ c[3];
		return {c[2], c[1], c[0] ^ inv, inv};
	endfunction

	function automatic logic [3:0] shsp_crc4_word(input logic [15:0] w);
		logic [3:0] c;
		c = SHSP_CRC4_PRESET;
		for (int i = 15; i >= 0; i--) begin
			c = shsp_crc4_step(c, w[i]);
		end
		return c;
	endfunction

	function automatic logic [2:0] shsp_crc3_step(input logic [2:0] c, input logic b);
		logic inv;
		inv = b ^ c[2];
		return {c[1], c[0] ^ inv, inv};
	endfunction
endpackage

//--- rtl/shsp_top.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module shsp_top #(
	parameter int HALF_W = 16
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_sclk,
	input  wire logic        i_serial_select_n,
	input  wire logic        i_mosi,
	output logic             o_miso,
	input  wire logic        i_supply_cmd,
	input  wire logic        i_pwm_angle,
	output logic             o_pwm_out,
	output logic             o_pwm_oe,
	output logic             o_link_mode
);
	import shsp_pkg::*;

	logic [2:0]        sclk_sy_reg, cs_sy_reg, sup_sy_reg;
	logic [1:0]        mosi_sy_reg;
	logic [2:0]        ctrl_reg;
	logic              ier_reg, crc_flag_reg;
	logic [4:0]        bit_cnt_reg;
	logic [19:0]       rx_reg, tx_reg;
	logic              rd_pend_reg;
	logic [5:0]        rd_addr_reg;
	logic [7:0]        mem [64];
	logic [1:0]        die_id_reg, id_cnt_reg;
	shsp_man_t         m_state_reg;
	logic [HALF_W-1:0] tim_reg, half_reg;
	logic [5:0]        idx_reg, len_reg;
	logic [31:0]       shf_reg;
	logic [2:0]        c3_reg;
	logic              mdone_reg, man_mode_reg;
	logic              tx_busy_reg, tx_ph_reg;
	logic [15:0]       txd_reg;
	logic [3:0]        tx_bits_reg;
	logic [HALF_W-1:0] tx_tim_reg;

	function automatic logic [15:0] read_word(input logic [5:0] a);
		if (a[5:1] == 5'h00)
			return 16'h0000;
		else if (a[0])
			return {8'h00, mem[a]};
		else
			return {mem[a], mem[{a[5:1], 1'b1}]};
	endfunction

	// Pin synchronisers and strobes
	wire sclk_rise = sclk_sy_reg[1] & ~sclk_sy_reg[2];
	wire sclk_fall = ~sclk_sy_reg[1] & sclk_sy_reg[2];
	wire cs_fall   = ~cs_sy_reg[1] & cs_sy_reg[2];
	wire cs_rise   = cs_sy_reg[1] & ~cs_sy_reg[2];
	wire cs_act    = ~cs_sy_reg[1];
	wire mosi_s    = mosi_sy_reg[1];
	wire s17       = ctrl_reg[SHSP_S17_BIT];
	wire hce       = ctrl_reg[SHSP_HCE_BIT];
	wire link_en   = ~ctrl_reg[SHSP_SLD_BIT];

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			sclk_sy_reg <= 3'h7;
			cs_sy_reg   <= 3'h7;
			sup_sy_reg  <= 3'h7;
			mosi_sy_reg <= 2'h0;
		end else begin
			sclk_sy_reg <= {sclk_sy_reg[1:0], i_sclk};
			cs_sy_reg   <= {cs_sy_reg[1:0], i_serial_select_n};
			sup_sy_reg  <= {sup_sy_reg[1:0], i_supply_cmd};
			mosi_sy_reg <= {mosi_sy_reg[0], i_mosi};
		end
	end

	// Serial frame evaluation at select release
	wire        len_ok   = bit_cnt_reg == SHSP_LEN_BASE || bit_cnt_reg == SHSP_LEN_CRC
	                       || (bit_cnt_reg == SHSP_LEN_EXT && s17);
	wire        over     = bit_cnt_reg > SHSP_LEN_BASE && !len_ok;
	wire [15:0] payload  = bit_cnt_reg == SHSP_LEN_CRC ? rx_reg[19:4] :
	                       bit_cnt_reg == SHSP_LEN_EXT ? rx_reg[16:1] : rx_reg[15:0];
	wire        crc_bad  = bit_cnt_reg == SHSP_LEN_CRC && hce
	                       && shsp_crc4_word(payload) != rx_reg[3:0];
	wire        spi_take = cs_rise && len_ok && !crc_bad && !payload[15];
	wire        spi_wr   = spi_take & payload[14];
	wire        spi_rd   = spi_take & ~payload[14];
	wire [15:0] resp     = rd_pend_reg ? read_word(rd_addr_reg) : 16'h0000;

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || cs_fall || cs_rise)
			bit_cnt_reg <= 5'h00;
		else if (cs_act && sclk_rise && bit_cnt_reg != 5'h1F)
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rx_reg <= 20'h00000;
			tx_reg <= 20'h00000;
			o_miso <= 1'b0;
		end else begin
			if (cs_act && sclk_rise)
				rx_reg <= {rx_reg[18:0], mosi_s};
			if (cs_fall)
				tx_reg <= {resp, shsp_crc4_word(resp)};
			else if (cs_act && sclk_fall) begin
				o_miso <= tx_reg[19];
				tx_reg <= {tx_reg[18:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= 6'h00;
		end else if (cs_rise) begin
			rd_pend_reg <= spi_rd;
			rd_addr_reg <= payload[13:8];
		end
	end

	// Die address strap, caught after the synchronisers settle
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			id_cnt_reg <= 2'h0;
			die_id_reg <= 2'h0;
		end else if (id_cnt_reg != SHSP_ID_SETTLE) begin
			id_cnt_reg <= id_cnt_reg + 2'h1;
			die_id_reg <= {mosi_s, cs_sy_reg[1]};
		end
	end

	// Supply-line decoder
	wire                sup_s  = sup_sy_reg[1];
	wire                s_edge = sup_s ^ sup_sy_reg[2];
	wire                s_rise = sup_s & ~sup_sy_reg[2];
	wire [HALF_W+1:0]   tim_x  = {2'b00, tim_reg};
	wire [HALF_W+1:0]   win_lo = {2'b00, half_reg} + {3'b000, half_reg[HALF_W-1:1]};
	wire [HALF_W+1:0]   win_hi = {1'b0, half_reg, 1'b0} + {3'b000, half_reg[HALF_W-1:1]};
	wire                mid    = m_state_reg == SHSP_M_BITS && s_edge && tim_x >= win_lo;
	wire                m_bit  = ~sup_s;
	wire [5:0]          len_e  = idx_reg == 6'h02 ?
	                             (m_bit ? SHSP_MAN_RD_LEN : SHSP_MAN_WR_LEN) : len_reg;
	wire                in_crc = idx_reg >= 6'h02 && idx_reg < len_e - 6'h03;
	wire                m_last = idx_reg == len_e - 6'h01;
	wire                m_abort = (m_state_reg == SHSP_M_BITS && tim_x > win_hi)
	                              || (mid && idx_reg == 6'h01 && m_bit);
	wire                tim_max = &tim_reg;

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || !link_en) begin
			m_state_reg <= SHSP_M_IDLE;
			mdone_reg   <= 1'b0;
		end else begin
			mdone_reg <= mid && m_last && !m_abort;
			case (m_state_reg)
				SHSP_M_IDLE: if (s_edge && !sup_s) m_state_reg <= SHSP_M_SYNC;
				SHSP_M_SYNC: begin
					if (s_rise)
						m_state_reg <= SHSP_M_BITS;
					else if (s_edge || tim_max)
						m_state_reg <= SHSP_M_IDLE;
				end
				SHSP_M_BITS: if (m_abort || (mid && m_last)) m_state_reg <= SHSP_M_IDLE;
				default: m_state_reg <= SHSP_M_IDLE;
			endcase
		end
	end

	// Restart at the sync mid-edge so the first data window is measured from it
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || m_state_reg == SHSP_M_IDLE || mid || (m_state_reg == SHSP_M_SYNC && s_rise))
			tim_reg <= '0;
		else if (!tim_max)
			tim_reg <= tim_reg + 1'b1;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			half_reg <= '1;
			idx_reg  <= 6'h00;
			len_reg  <= SHSP_MAN_WR_LEN;
			shf_reg  <= 32'h00000000;
			c3_reg   <= SHSP_CRC3_PRESET;
		end else if (m_state_reg == SHSP_M_SYNC && s_rise) begin
			half_reg <= tim_max ? tim_reg : tim_reg + 1'b1;
			idx_reg  <= 6'h01;
			len_reg  <= SHSP_MAN_WR_LEN;
			shf_reg  <= 32'h00000000;
			c3_reg   <= SHSP_CRC3_PRESET;
		end else if (mid) begin
			idx_reg <= idx_reg + 6'h01;
			len_reg <= len_e;
			shf_reg <= {shf_reg[30:0], m_bit};
			if (in_crc)
				c3_reg <= shsp_crc3_step(c3_reg, m_bit);
		end
	end

	// Command decode after a complete frame
	wire        m_rd     = len_reg == SHSP_MAN_RD_LEN;
	wire [3:0]  m_mask   = m_rd ? shf_reg[12:9] : shf_reg[28:25];
	wire [5:0]  m_addr   = m_rd ? shf_reg[8:3] : shf_reg[24:19];
	wire [15:0] m_data   = shf_reg[18:3];
	wire        m_sel    = m_mask == 4'h0 || m_mask[die_id_reg];
	wire        man_ok   = mdone_reg && c3_reg == shf_reg[2:0] && link_en;
	wire        m_spec   = !m_rd && m_addr == SHSP_ACCESS_ADDR;
	wire        m_access = man_ok && m_spec && m_data == SHSP_ACCESS_DATA;
	wire        m_exit   = man_ok && m_spec && m_data == SHSP_EXIT_DATA && m_sel;
	wire        man_wr   = man_ok && man_mode_reg && !m_rd && m_sel && !m_spec;
	wire        tx_start = man_ok && man_mode_reg && m_rd && m_sel;

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || !link_en)
			man_mode_reg <= 1'b0;
		else if (m_access)
			man_mode_reg <= 1'b1;
		else if (m_exit && man_mode_reg)
			man_mode_reg <= 1'b0;
	end

	// Primary register bytes; serial port wins a same-cycle clash
	always_ff @(posedge i_sys_clk) begin
		if (spi_wr)
			mem[payload[13:8]] <= payload[7:0];
		else if (man_wr) begin
			mem[{m_addr[5:1], 1'b0}] <= m_data[15:8];
			mem[{m_addr[5:1], 1'b1}] <= m_data[7:0];
		end
	end

	// Reply transmitter at the measured half-bit period
	wire tx_tick  = tx_tim_reg == half_reg - 1'b1;
	wire tx_level = txd_reg[15] ^ tx_ph_reg;
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			tx_busy_reg <= 1'b0;
			tx_ph_reg   <= 1'b0;
			txd_reg     <= 16'h0000;
			tx_bits_reg <= 4'h0;
			tx_tim_reg  <= '0;
		end else if (tx_start) begin
			tx_busy_reg <= 1'b1;
			tx_ph_reg   <= 1'b0;
			txd_reg     <= read_word(m_addr);
			tx_bits_reg <= 4'h0;
			tx_tim_reg  <= '0;
		end else if (tx_busy_reg) begin
			tx_tim_reg <= tx_tick ? '0 : tx_tim_reg + 1'b1;
			if (tx_tick) begin
				tx_ph_reg <= ~tx_ph_reg;
				if (tx_ph_reg) begin
					txd_reg     <= {txd_reg[14:0], 1'b0};
					tx_bits_reg <= tx_bits_reg + 4'h1;
					tx_busy_reg <= tx_bits_reg != 4'hF;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_pwm_oe    <= 1'b0;
			o_pwm_out   <= 1'b0;
			o_link_mode <= 1'b0;
		end else begin
			o_pwm_oe    <= man_mode_reg ? tx_busy_reg & ~tx_level : ~i_pwm_angle;
			o_pwm_out   <= 1'b0;
			o_link_mode <= man_mode_reg;
		end
	end

	// Bus slave, one wait state
	wire        apb_acc  = i_psel && i_penable && !o_pready;
	wire        hit_ctrl = i_paddr == SHSP_CTRL_OFS;
	wire        hit_stat = i_paddr == SHSP_STAT_OFS;
	wire        apb_w    = apb_acc && i_pwrite;
	wire        clr_ier  = apb_w && hit_stat && i_pwdata[SHSP_IER_BIT];
	wire        clr_crc  = apb_w && hit_stat && i_pwdata[SHSP_CRC_BIT];
	wire [31:0] stat_val = {26'h0, die_id_reg, tx_busy_reg, man_mode_reg, crc_flag_reg, ier_reg};
	wire [31:0] rd_val   = hit_ctrl ? {29'h0, ctrl_reg} : hit_stat ? stat_val : 32'h0;
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
			ctrl_reg  <= SHSP_CTRL_RST;
		end else begin
			o_pready  <= apb_acc;
			o_pslverr <= apb_acc && !hit_ctrl && !hit_stat;
			o_prdata  <= (apb_acc && !i_pwrite) ? rd_val : 32'h00000000;
			if (apb_w && hit_ctrl)
				ctrl_reg <= i_pwdata[2:0];
		end
	end

	// Warning flags, a set beats a same-cycle clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			ier_reg      <= 1'b0;
			crc_flag_reg <= 1'b0;
		end else begin
			ier_reg      <= (cs_rise && over) || (ier_reg && !clr_ier);
			crc_flag_reg <= (cs_rise && crc_bad) || (crc_flag_reg && !clr_crc);
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	property p_ier_excess;
		cs_rise && bit_cnt_reg == 5'h12 |=> ier_reg;
	endproperty
	a_ier_excess: assert property (p_ier_excess) else $error("excess clocks not flagged");
	property p_ier_clean;
		cs_rise && bit_cnt_reg == SHSP_LEN_CRC && !ier_reg |=> !ier_reg;
	endproperty
	a_ier_clean: assert property (p_ier_clean) else $error("clean frame flagged");
	property p_s17;
		cs_rise && bit_cnt_reg == SHSP_LEN_EXT && !ier_reg |=> ier_reg == !$past(s17);
	endproperty
	a_s17: assert property (p_s17) else $error("17-bit frame handling wrong");
	property p_crc_bad;
		cs_rise && crc_bad |=> crc_flag_reg && !rd_pend_reg;
	endproperty
	a_crc_bad: assert property (p_crc_bad) else $error("bad check frame accepted");
	property p_tx_crc;
		cs_fall |=> tx_reg[3:0] == shsp_crc4_word(tx_reg[19:4]);
	endproperty
	a_tx_crc: assert property (p_tx_crc) else $error("outgoing check code wrong");
	property p_pipe;
		cs_rise && spi_rd |=> rd_pend_reg && rd_addr_reg == $past(payload[13:8]);
	endproperty
	a_pipe: assert property (p_pipe) else $error("read not held for next frame");
	property p_odd;
		cs_fall && rd_pend_reg && rd_addr_reg[0] |=> tx_reg[19:12] == 8'h00;
	endproperty
	a_odd: assert property (p_odd) else $error("odd read upper byte not zero");
	property p_zero;
		cs_fall && rd_addr_reg == 6'h00 |=> tx_reg[19:4] == 16'h0000;
	endproperty
	a_zero: assert property (p_zero) else $error("address zero read not zero");
	property p_miso;
		cs_act && sclk_fall && !cs_fall |=> o_miso == $past(tx_reg[19]);
	endproperty
	a_miso: assert property (p_miso) else $error("miso not shifted on falling edge");
	property p_disable;
		!link_en |=> !man_mode_reg ##1 !o_link_mode;
	endproperty
	a_disable: assert property (p_disable) else $error("link active while disabled");
	property p_enter;
		$rose(man_mode_reg) && !tx_busy_reg |=> !o_pwm_oe;
	endproperty
	a_enter: assert property (p_enter) else $error("angle output not stopped");
	property p_reply;
		tx_start |=> tx_busy_reg [*8];
	endproperty
	a_reply: assert property (p_reply) else $error("reply not sent after read");
	property p_locked;
		!man_mode_reg && !m_access |=> !tx_busy_reg || $past(tx_busy_reg);
	endproperty
	a_locked: assert property (p_locked) else $error("acted before access code");
endmodule // shsp_top

//--- verif/shsp_host_model.sv
`timescale 1ns/1ps
module shsp_host_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_miso,
	output logic             o_sclk,
	output logic             o_select_n,
	output logic             o_mosi,
	output logic [19:0]      o_rx,
	output logic             o_done
);
	initial begin
		o_sclk = 1'b1;
		o_select_n = 1'b1;
		o_mosi = 1'b1;
		o_rx = 20'h0;
		o_done = 1'b0;
	end

	// One frame, 8 clocks per bit, clock idles high
	task automatic xfer(input logic [19:0] w, input int n, input logic chk);
		logic [19:0] r;
		r = 20'h0;
		@(posedge i_sys_clk);
		o_select_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (3) @(posedge i_sys_clk);
			o_sclk <= 1'b0;
			o_mosi <= w[i];
			repeat (5) @(posedge i_sys_clk);
			r = {r[18:0], i_miso};
			o_sclk <= 1'b1;
		end
		repeat (3) @(posedge i_sys_clk);
		o_select_n <= 1'b1;
		o_mosi <= ~o_mosi;
		o_rx <= r;
		o_done <= chk;
		@(posedge i_sys_clk);
		o_done <= 1'b0;
		repeat (6) @(posedge i_sys_clk);
	endtask
endmodule // shsp_host_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import shsp_pkg::*;
	localparam int H = 20;
	logic        clk, rst_n, psel, penable, pwrite, sup, angle;
	logic        pready, pslverr, sclk, sel_n, mosi, miso, pwm_out, pwm_oe, link, sdone;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, seed, d;
	logic [19:0] srx;
	logic [32:0] q_apb[$];
	logic [19:0] q_spi[$];
	int          error_cnt, checks_done;
	event        mid_ev;

	shsp_top #(.HALF_W(16)) shsp_top_i (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_sclk(sclk), .i_serial_select_n(sel_n),
		.i_mosi(mosi), .o_miso(miso), .i_supply_cmd(sup), .i_pwm_angle(angle),
		.o_pwm_out(pwm_out), .o_pwm_oe(pwm_oe), .o_link_mode(link));

	shsp_host_model shsp_host_model_i (
		.i_sys_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_select_n(sel_n),
		.o_mosi(mosi), .o_rx(srx), .o_done(sdone));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [3:0] crc4(input logic [15:0] w);
		logic [3:0] c;
		logic       v;
		c = 4'hF;
		for (int i = 15; i >= 0; i--) begin
			v = w[i] ^ c[3];
			c = {c[2:1], c[0] ^ v, v};
		end
		return c;
	endfunction

	task automatic cmp_word(input logic [32:0] g, input logic [32:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp_bit(input logic g, input logic e);
		cmp_word({32'h0, g}, {32'h0, e});
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q_apb.push_back(e);
		apb(1'b0, a, seed);
	endtask

	task automatic spi(input logic [15:0] w, input int n, input logic bad, input logic chk,
			input logic [15:0] e);
		logic [19:0] f;
		f = (n == 20) ? {w, crc4(w) ^ {4{bad}}} : ((n == 17) ? {3'h0, w, 1'b0} : {4'h0, w});
		if (chk) begin
			q_spi.push_back((n == 20) ? {e, crc4(e)} : {4'h0, e});
		end
		shsp_host_model_i.xfer(f, n, chk);
	endtask

	task automatic half(input logic l);
		sup <= l;
		repeat (H) @(posedge clk);
	endtask

	// Supply-line command, host always initiates
	task automatic man(input logic rw, input logic [3:0] m, input logic [5:0] a,
			input logic [15:0] v);
		logic [31:0] f;
		logic [2:0]  c;
		int          n;
		n = rw ? 16 : 32;
		f = rw ? {2'b00, rw, m, a, 19'h0} : {2'b00, rw, m, a, v, 3'h0};
		c = 3'h7;
		for (int i = 29; i >= 35 - n; i--) begin
			c = {c[1], c[0] ^ f[i] ^ c[2], f[i] ^ c[2]};
		end
		f[34 - n -: 3] = c;
		for (int i = 31; i >= 32 - n; i--) begin
			half(f[i]);
			if (i == 32 - n) begin
				-> mid_ev;
			end
			half(~f[i]);
		end
		repeat (4) half(1'b1);
	endtask

	// Samples each reply half-bit at its centre
	task automatic reply(input logic [15:0] e);
		logic [31:0] g, x;
		@(mid_ev);
		repeat (2 + H / 2) @(posedge clk);
		for (int i = 15; i >= 0; i--) begin
			x[2 * i +: 2] = {~e[i], e[i]};
			g[2 * i + 1] = pwm_oe;
			repeat (H) @(posedge clk);
			g[2 * i] = pwm_oe;
			repeat (H) @(posedge clk);
		end
		cmp_word({1'b0, g}, {1'b0, x});
	endtask

	always @(posedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0) begin
			cmp_word({pslverr, prdata}, q_apb.pop_front());
		end
		if (sdone === 1'b1) begin
			cmp_word({13'h0, srx}, {13'h0, q_spi.pop_front()});
		end
	end

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sup = 1'b1;
		angle = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		seed = lfsr(32'hD15A25C0);
		d = seed;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		rd(SHSP_CTRL_OFS, {30'h0, SHSP_CTRL_RST});
		rd(SHSP_STAT_OFS, 33'h30);
		rd(8'h08, {1'b1, 32'h0});
		spi({8'h52, d[7:0]}, 16, 0, 0, 0);
		spi({8'h53, d[15:8]}, 20, 0, 0, 0);
		spi(16'h1200, 16, 0, 0, 0);
		spi(16'h1300, 20, 0, 1, {d[7:0], d[15:8]});
		spi(16'h0000, 16, 0, 1, {8'h00, d[15:8]});
		spi(16'h0000, 20, 0, 1, 16'h0000);
		rd(SHSP_STAT_OFS, 33'h30);
		apb(1'b1, SHSP_CTRL_OFS, 32'h1);
		spi(16'h0000, 17, 0, 0, 0);
		rd(SHSP_STAT_OFS, 33'h30);
		apb(1'b1, SHSP_CTRL_OFS, 32'h2);
		spi({8'h52, d[23:16]}, 20, 0, 0, 0);
		spi({8'h52, ~d[23:16]}, 20, 1, 0, 0);
		spi(16'h1200, 20, 0, 0, 0);
		spi(16'h0000, 20, 0, 1, {d[23:16], d[15:8]});
		rd(SHSP_STAT_OFS, 33'h32);
		apb(1'b1, SHSP_CTRL_OFS, 32'h0);
		spi(16'h0000, 17, 0, 0, 0);
		rd(SHSP_STAT_OFS, 33'h33);
		apb(1'b1, SHSP_STAT_OFS, 32'h3);
		rd(SHSP_STAT_OFS, 33'h30);
		spi(16'h0000, 18, 0, 0, 0);
		rd(SHSP_STAT_OFS, 33'h31);
		apb(1'b1, SHSP_CTRL_OFS, 32'h4);
		man(1'b0, 4'h0, SHSP_ACCESS_ADDR, SHSP_ACCESS_DATA);
		cmp_bit(link, 1'b0);
		apb(1'b1, SHSP_CTRL_OFS, 32'h0);
		man(1'b1, 4'h8, 6'h12, 16'h0);
		cmp_bit(link, 1'b0);
		cmp_bit(pwm_oe, 1'b1);
		man(1'b0, 4'h1, SHSP_ACCESS_ADDR, SHSP_ACCESS_DATA);
		cmp_bit(link, 1'b1);
		cmp_bit(pwm_oe, 1'b0);
		seed = lfsr(seed);
		man(1'b0, 4'h0, 6'h14, seed[15:0]);
		fork
			man(1'b1, 4'h8, 6'h14, 16'h0);
			reply(seed[15:0]);
		join
		man(1'b0, 4'h8, SHSP_ACCESS_ADDR, SHSP_EXIT_DATA);
		cmp_bit(link, 1'b0);
		cmp_bit(pwm_oe, 1'b1);
		cmp_bit(pwm_out, 1'b0);
		finish_test();
	end
endmodule // tb_top
